// ---- logic/oxtr_top.sv ----
// octal bus transceiver with two storage registers and a register port
//
// The plain strobed port and the address map were chosen for this implementation.
`default_nettype none

module oxtr_top
  import oxtr_pkg::*;
#(
  parameter int W = oxtr_pkg::BUS_W
)(
  // clock and reset
  input  wire logic                      CLK_SYS,
  input  wire logic                      RSTN,
  // register port
  input  wire logic [oxtr_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [oxtr_pkg::REG_W-1:0]  WR_DATA,
  input  wire logic                      WR_EN,
  input  wire logic                      RD_EN,
  output logic      [oxtr_pkg::REG_W-1:0]  RD_DATA,
  // control pins
  input  wire logic                      A_SIDE_CAPTURE_CLOCK,
  input  wire logic                      B_SIDE_CAPTURE_CLOCK,
  input  wire logic                      DRIVE_EN_N,
  input  wire logic                      DIR,
  input  wire logic                      A_TO_B_SOURCE_SELECT,
  input  wire logic                      B_TO_A_SOURCE_SELECT,
  // bus A
  input  wire logic [oxtr_pkg::BUS_W-1:0]  A_IN,
  output logic      [oxtr_pkg::BUS_W-1:0]  A_OUT,
  output logic                           A_OE_N,
  // bus B
  input  wire logic [oxtr_pkg::BUS_W-1:0]  B_IN,
  output logic      [oxtr_pkg::BUS_W-1:0]  B_OUT,
  output logic                           B_OE_N
);
  import oxtr_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire  logic [PIN_W-1:0] pin_raw;
  logic       [PIN_W-1:0] s1;
  logic       [PIN_W-1:0] s2;
  logic       [PIN_W-1:0] s3;
  logic       [PIN_W-1:0] filt;
  wire  logic [PIN_W-1:0] next_filt;

  assign pin_raw = {B_TO_A_SOURCE_SELECT, A_TO_B_SOURCE_SELECT, DIR,
                    DRIVE_EN_N, B_SIDE_CAPTURE_CLOCK,
                    A_SIDE_CAPTURE_CLOCK, B_IN, A_IN};
  // a bit moves only when stages two and three agree
  assign next_filt = (s2 & s3) | (filt & (s2 ^ s3));

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      s1   <= PIN_RST;
      s2   <= PIN_RST;
      s3   <= PIN_RST;
      filt <= PIN_RST;
    end
    else
    begin
      s1   <= pin_raw;
      s2   <= s1;
      s3   <= s2;
      filt <= next_filt;
    end
  end

  wire logic [W-1:0] a_f;
  wire logic [W-1:0] b_f;
  wire logic         en_f;
  wire logic         dir_f;
  wire logic         sab_f;
  wire logic         sba_f;

  assign a_f   = filt[PIN_A_LSB +: W];
  assign b_f   = filt[PIN_B_LSB +: W];
  assign en_f  = ~filt[PIN_EN_N];
  assign dir_f = filt[PIN_DIR];
  assign sab_f = filt[PIN_SAB];
  assign sba_f = filt[PIN_SBA];

  // ----------------------------------------------------------------
  // storage registers
  // ----------------------------------------------------------------
  logic       [1:0]   cap_prev;
  logic       [W-1:0] reg_a;
  logic       [W-1:0] reg_b;
  wire  logic         cap_a_evt;
  wire  logic         cap_b_evt;

  // rising edge of a filtered level against last cycle's copy
  function automatic logic rose_from(input logic now_lvl,
                                     input logic was_lvl);
    return now_lvl & ~was_lvl;
  endfunction

  // edges are taken from the filtered level, not gated by enable;
  // a clock pulse shorter than the filter span is simply lost
  assign cap_a_evt = rose_from(filt[PIN_CAPA], cap_prev[0]);
  assign cap_b_evt = rose_from(filt[PIN_CAPB], cap_prev[1]);

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      cap_prev <= 2'h3;
      reg_a    <= DATA_RST;
      reg_b    <= DATA_RST;
    end
    else
    begin
      cap_prev <= {filt[PIN_CAPB], filt[PIN_CAPA]};
      if (cap_a_evt)
        reg_a <= a_f;
      if (cap_b_evt)
        reg_b <= b_f;
    end
  end

  // ----------------------------------------------------------------
  // output steering
  // ----------------------------------------------------------------
  logic               invert;
  wire  logic         drive_a;
  wire  logic         drive_b;
  wire  logic [W-1:0] src_to_a;
  wire  logic [W-1:0] src_to_b;
  wire  logic [W-1:0] next_a_out;
  wire  logic [W-1:0] next_b_out;

  // while enabled, direction picks exactly one side; released drives neither, so both can never be on
  assign drive_a  = en_f & ~dir_f;
  assign drive_b  = en_f & dir_f;
  assign src_to_a = sba_f ? reg_b : b_f;
  assign src_to_b = sab_f ? reg_a : a_f;
  // per-bit inversion keeps bit n of one side paired with bit n
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    assign next_a_out[i] = src_to_a[i] ^ invert;
    assign next_b_out[i] = src_to_b[i] ^ invert;
  end

  // outputs follow controls every cycle, no capture edge needed
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      A_OUT  <= DATA_RST;
      B_OUT  <= DATA_RST;
      A_OE_N <= 1'b1;
      B_OE_N <= 1'b1;
    end
    else
    begin
      A_OUT  <= next_a_out;
      B_OUT  <= next_b_out;
      A_OE_N <= ~drive_a;
      B_OE_N <= ~drive_b;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  wire logic [REG_W-1:0] rd_mux;
  wire logic [REG_W-1:0] stat_word;

  assign stat_word = REG_W'({drive_b, drive_a});
  assign rd_mux = (ADDR == OFS_CTRL)  ? REG_W'(invert) :
                  (ADDR == OFS_REG_A) ? REG_W'(reg_a)  :
                  (ADDR == OFS_REG_B) ? REG_W'(reg_b)  :
                  (ADDR == OFS_STAT)  ? stat_word      : RD_IDLE;

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      invert  <= CTRL_INV_RST;
      RD_DATA <= RD_IDLE;
    end
    else
    begin
      if (WR_EN && ADDR == OFS_CTRL)
        invert <= WR_DATA[CTRL_INV_BIT];
      RD_DATA <= RD_EN ? rd_mux : RD_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // checker helpers
  // ----------------------------------------------------------------
  // counts cycles in which neither capture clock moved, saturating;
  // it only feeds the assertion and the cover below and has no effect on the pins
  logic       [1:0] quiet_cnt;
  wire  logic       quiet_now;

  assign quiet_now = (filt[PIN_CAPA] == cap_prev[0]) &&
                     (filt[PIN_CAPB] == cap_prev[1]);

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      quiet_cnt <= '0;
    else if (!quiet_now)
      quiet_cnt <= '0;
    else if (quiet_cnt != '1)
      quiet_cnt <= quiet_cnt + 2'h1;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  a_no_dual_drive: assert property (A_OE_N || B_OE_N)
    else $error("both buses driven");
  a_capture_a_load: assert property
    (cap_a_evt |=> reg_a == $past(a_f))
    else $error("A register missed capture");
  a_capture_b_load: assert property
    (cap_b_evt |=> reg_b == $past(b_f))
    else $error("B register missed capture");
  a_hold_a_reg: assert property (!cap_a_evt |=> $stable(reg_a))
    else $error("A register changed without edge");
  a_hold_steady_clk: assert property
    ($stable(filt[PIN_CAPB]) [*2] |=> $stable(reg_b))
    else $error("B register changed with steady clock");
  a_capture_ungated: assert property
    (cap_a_evt && !en_f |=> reg_a == $past(a_f))
    else $error("capture blocked while released");
  a_release_both: assert property
    (!en_f |=> A_OE_N && B_OE_N)
    else $error("bus driven while released");
  a_live_b_to_a: assert property
    (drive_a && !sba_f && !invert |=> !A_OE_N && A_OUT == $past(b_f))
    else $error("live B not on A");
  a_stored_b_to_a: assert property
    (drive_a && sba_f && !invert |=> A_OUT == $past(reg_b))
    else $error("stored B not on A");
  a_live_a_to_b: assert property
    (drive_b && !sab_f && !invert |=> !B_OE_N && B_OUT == $past(a_f))
    else $error("live A not on B");
  a_stored_a_to_b: assert property
    (drive_b && sab_f && !invert |=> B_OUT == $past(reg_a))
    else $error("stored A not on B");
  a_invert_data: assert property
    (drive_b && invert |=> B_OUT == ~$past(src_to_b))
    else $error("inverted data wrong");
  a_dir_turnaround: assert property
    ($rose(dir_f) && en_f |-> ##1 (!B_OE_N && A_OE_N))
    else $error("direction change late");

  // inverted paths other than live A to B, the control write and the quiet hold are checked
  // apart so that a broken select cannot hide behind the invert
  a_hold_b_reg: assert property (!cap_b_evt |=> $stable(reg_b))
    else $error("B register changed without edge");
  a_capture_while_drive: assert property
    (cap_b_evt && en_f |=> reg_b == $past(b_f))
    else $error("capture blocked while driving");
  a_quiet_hold: assert property
    (quiet_cnt == '1 |-> $stable(reg_a) && $stable(reg_b))
    else $error("register moved with quiet clocks");
  a_invert_live_b: assert property
    (drive_a && invert && !sba_f |=> A_OUT == ~$past(b_f))
    else $error("inverted live B not on A");
  a_invert_stored_b: assert property
    (drive_a && invert && sba_f |=> A_OUT == ~$past(reg_b))
    else $error("inverted stored B not on A");
  a_invert_stored_a: assert property
    (drive_b && invert && sab_f |=> B_OUT == ~$past(reg_a))
    else $error("inverted stored A not on B");
  a_ctrl_write: assert property
    (WR_EN && ADDR == OFS_CTRL |=> invert == $past(WR_DATA[CTRL_INV_BIT]))
    else $error("invert control not written");
  a_enable_one_side: assert property
    (en_f |=> A_OE_N != B_OE_N)
    else $error("enabled without exactly one side");
  a_dir_to_a: assert property
    ($fell(dir_f) && en_f |-> ##1 (!A_OE_N && B_OE_N))
    else $error("turn to A side late");
  a_stat_one_side: assert property
    (RD_EN && ADDR == OFS_STAT |=> RD_DATA[1:0] != 2'h3)
    else $error("status shows both sides driven");

  c_both_captured: cover property (cap_a_evt && cap_b_evt);
  c_stored_to_a: cover property (drive_a && sba_f ##1 !A_OE_N);
  c_live_to_b: cover property (drive_b && !sab_f ##1 !B_OE_N);
  c_invert_read: cover property (invert && RD_EN ##1 RD_DATA != RD_IDLE);
  c_quiet_drive: cover property (quiet_cnt == '1 && drive_b);

endmodule

`default_nettype wire

// ---- logic/oxtr_pkg.sv ----
// constants for the octal bus transceiver with storage registers
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`default_nettype none

package oxtr_pkg;
  localparam int BUS_W  = 8;
  localparam int ADDR_W = 4;
  localparam int REG_W  = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_REG_A = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_REG_B = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STAT  = 4'hC;
  localparam int CTRL_INV_BIT  = 0;
  localparam int STAT_DRV_A    = 0;
  localparam int STAT_DRV_B    = 1;
  localparam logic CTRL_INV_RST = 1'b0;

  // layout of the synchronised pin vector
  localparam int PIN_W     = 2 * BUS_W + 6;
  localparam int PIN_A_LSB = 0;
  localparam int PIN_B_LSB = BUS_W;
  localparam int PIN_CAPA  = 2 * BUS_W;
  localparam int PIN_CAPB  = 2 * BUS_W + 1;
  localparam int PIN_EN_N  = 2 * BUS_W + 2;
  localparam int PIN_DIR   = 2 * BUS_W + 3;
  localparam int PIN_SAB   = 2 * BUS_W + 4;
  localparam int PIN_SBA   = 2 * BUS_W + 5;
  // drive enable starts released so nothing is driven out of reset
  localparam logic [PIN_W-1:0] PIN_RST = 22'h04_0000;
  localparam logic [BUS_W-1:0] DATA_RST = 8'h00;
  localparam logic [REG_W-1:0] RD_IDLE  = 8'h00;
endpackage

`default_nettype wire

// ---- sim/oxtr_far_bus.sv ----
// far-side bus logic model: drives each bus only while the device lets go
`default_nettype none
module oxtr_far_bus
(
  // device side
  input  wire logic [7:0] a_out,
  input  wire logic       a_oe_n,
  input  wire logic [7:0] b_out,
  input  wire logic       b_oe_n,
  // far-side data and resolved wires
  input  wire logic [7:0] a_drv,
  input  wire logic [7:0] b_drv,
  output logic      [7:0] a_in,
  output logic      [7:0] b_in
);
  // far logic backs off while the device drives, so the wire is its value
  assign a_in = a_oe_n ? a_drv : a_out;
  assign b_in = b_oe_n ? b_drv : b_out;
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for the octal bus transceiver
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import oxtr_pkg::*;
  logic              clk_sys, rstn, wr_en, rd_en, rd_d, cap_a, cap_b;
  logic              en_n, dir, a2b_sel, b2a_sel, a_oe_n, b_oe_n;
  logic [ADDR_W-1:0] addr;
  logic [REG_W-1:0]  wr_data, rd_data, rd_q[$];
  logic [BUS_W-1:0]  a_in, a_out, b_in, b_out, a_drv, b_drv, ra, rb, m, e;
  logic [16:0]       seed;
  int                error_cnt, cmp_count;

  oxtr_top oxtr_top_i (.CLK_SYS(clk_sys), .RSTN(rstn), .ADDR(addr),
    .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data),
    .A_SIDE_CAPTURE_CLOCK(cap_a), .B_SIDE_CAPTURE_CLOCK(cap_b),
    .DRIVE_EN_N(en_n), .DIR(dir), .A_TO_B_SOURCE_SELECT(a2b_sel),
    .B_TO_A_SOURCE_SELECT(b2a_sel), .A_IN(a_in), .A_OUT(a_out),
    .A_OE_N(a_oe_n), .B_IN(b_in), .B_OUT(b_out), .B_OE_N(b_oe_n));
  oxtr_far_bus oxtr_far_bus_i (.a_out(a_out), .a_oe_n(a_oe_n),
    .b_out(b_out), .b_oe_n(b_oe_n), .a_drv(a_drv), .b_drv(b_drv),
    .a_in(a_in), .b_in(b_in));

  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] s);
    cmp_count++;
    if (s !== x)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a; wr_data <= d; wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk_sys);
    addr <= a; rd_en <= 1'b1; rd_q.push_back(x);
    @(posedge clk_sys);
    rd_en <= 1'b0;
  endtask
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  // bus held steady around the capture edge, as the pin sync needs
  task automatic new_data;
    seed = lfsr(seed);
    a_drv <= seed[7:0];
    seed = lfsr(seed);
    b_drv <= seed[7:0];
    step(5);
  endtask
  task automatic cap(input bit b);
    if (b) cap_b <= 1'b1; else cap_a <= 1'b1;
    step(4);
    cap_a <= 1'b0; cap_b <= 1'b0;
    step(4);
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk_sys)
  begin
    rd_d <= rd_en;
    if (rd_d) chk("rd_data", rd_q.pop_front(), rd_data);
    if (rstn) chk("one_driver", 8'h01, {7'h0, a_oe_n | b_oe_n});
  end

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    #2000000;
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    {rstn, wr_en, rd_en, cap_a, cap_b, dir, a2b_sel, b2a_sel} = '0;
    en_n = 1'b1; addr = '0; wr_data = '0; a_drv = '0; b_drv = '0;
    seed = 17'd81741; error_cnt = 0; cmp_count = 0;
    step(3);
    rstn <= 1'b1;
    new_data();
    ra = a_drv; rb = b_drv;
    cap(0);
    cap(1);
    rd(OFS_REG_A, ra);
    rd(OFS_REG_B, rb);
    chk("oe_released", 8'h03, {6'h0, a_oe_n, b_oe_n});
    new_data();
    ra = a_drv;
    cap(0);
    wr(OFS_REG_A, ~ra);
    rd(OFS_REG_A, ra);
    rd(OFS_REG_B, rb);
    rd(4'h3, 8'h00);
    $display("test isolated capture done");
    for (int i = 0; i < 8; i++)
    begin
      m = {8{i[2]}};
      wr(OFS_CTRL, {7'h0, i[2]});
      en_n <= 1'b0; dir <= i[1]; a2b_sel <= i[0]; b2a_sel <= i[0];
      // a turned-round bus must refilter before its live data shows
      step(11);
      e = i[1] ? (i[0] ? ra : a_drv) : (i[0] ? rb : b_drv);
      chk("oe_pair", {6'h0, i[1], ~i[1]}, {6'h0, a_oe_n, b_oe_n});
      chk("bus_out", e ^ m, i[1] ? b_out : a_out);
      rd(OFS_STAT, {6'h0, i[1], ~i[1]});
      if (i == 6)
      begin
        cap(1);
        rb = a_drv ^ m;
        rd(OFS_REG_B, rb);
      end
    end
    en_n <= 1'b1;
    step(6);
    chk("oe_released", 8'h03, {6'h0, a_oe_n, b_oe_n});
    $display("test drive modes done");
    step(4);
    report_and_stop();
  end
endmodule
`default_nettype wire
